/* File: include/sram_link_pkg.sv */
// Shared constants for the split-port burst memory link.
// Assumes one system clock; each link cycle is two clock phases.
`default_nettype none
package sram_link_pkg;
  localparam int LANE_W        = 9;   // Bits per byte lane
  localparam int DATA_W_DEF    = 18;  // Default data width
  localparam int ADDR_W_X9     = 23;
  localparam int ADDR_W_X18    = 22;
  localparam int ADDR_W_X36    = 21;
  localparam int MEM_AW_DEF    = 4;   // Address bits; 16 locations kept in flip-flops
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int LAT_PLL_PH    = 3;   // 1.5 link cycles, in phases
  localparam int LAT_BYPASS_PH = 2;   // 1 link cycle, in phases
  localparam int PIPE_LEN      = 3;
  localparam logic RST_LOW     = 1'b0;
  localparam logic RST_HIGH    = 1'b1;

  // Address width follows the data width
  function automatic int addr_width(input int dw);
    addr_width = (dw == 9) ? ADDR_W_X9 : (dw == 18) ? ADDR_W_X18 : ADDR_W_X36;
  endfunction
endpackage
`default_nettype wire

/* File: include/sram_link_if.sv */
// Pin bundle between memory controller and burst memory.
// Assumes both ends share one clock; q holds its last value while q_oe is low.
`timescale 1ns/1ns
`default_nettype none
interface sram_link_if #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF
);
  localparam int AW    = sram_link_pkg::addr_width(DATA_W);
  localparam int LANES = DATA_W / sram_link_pkg::LANE_W;

  logic              k;
  logic              k_n;
  logic              c;
  logic              c_n;
  logic [AW-1:0]     addr;
  logic              read_port_enable_n;
  logic              write_port_enable_n;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0]  byte_lane_write_mask_n;
  logic [DATA_W-1:0] q;
  logic              q_oe;
  logic              echo_strobe;
  logic              echo_strobe_n;
  logic              pll_bypass_n;
  logic              single_clock_mode;

  modport device (
    input  k, k_n, c, c_n, addr, read_port_enable_n, write_port_enable_n,
    input  d, byte_lane_write_mask_n, pll_bypass_n, single_clock_mode,
    output q, q_oe, echo_strobe, echo_strobe_n
  );
  modport host (
    output k, k_n, c, c_n, addr, read_port_enable_n, write_port_enable_n,
    output d, byte_lane_write_mask_n, pll_bypass_n, single_clock_mode,
    input  q, q_oe, echo_strobe, echo_strobe_n
  );
endinterface
`default_nettype wire

/* File: hw/cmd_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; ce low freezes all state.
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sram_link_pkg::FIFO_DEPTH_DEF
) (
  // Clocking
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             ready_q;

  // Handshakes
  wire           push     = ce & in_valid & ready_q;
  wire           pop      = ce & out_valid & out_ready;
  wire [CW-1:0]  count_d  = count_q + CW'(push) - CW'(pop);
  wire [PW-1:0]  wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
  wire [PW-1:0]  rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);

  assign in_ready  = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = store_q[rd_ptr_q];

  // Pointers and a registered ready, so full is honest one cycle ahead
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= sram_link_pkg::RST_HIGH;
    end else if (ce) begin
      if (push) wr_ptr_q <= wr_ptr_d;
      if (pop) rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      ready_q <= (count_d != CW'(DEPTH));
    end
  end

  // Storage needs no reset
  always_ff @(posedge clock) begin
    if (push) store_q[wr_ptr_q] <= in_data;
  end
endmodule // cmd_fifo
`default_nettype wire

/* File: hw/sram_port_host.sv */
// Memory controller end: queues commands, drives clocks and pins.
// Assumes the link's k pair is made here by halving the system clock.
`timescale 1ns/1ns
`default_nettype none
module sram_port_host #(
  parameter int DATA_W     = sram_link_pkg::DATA_W_DEF,
  parameter int FIFO_DEPTH = sram_link_pkg::FIFO_DEPTH_DEF
) (
  // Clocking
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // Command queue
  input  wire logic                cmd_valid,
  output var  logic                cmd_ready,
  input  wire logic                cmd_write,
  input  wire logic [sram_link_pkg::addr_width(DATA_W)-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0]   cmd_data0,
  input  wire logic [DATA_W-1:0]   cmd_data1,
  input  wire logic [DATA_W/9-1:0] cmd_mask0_n,
  input  wire logic [DATA_W/9-1:0] cmd_mask1_n,
  // Mode levels
  input  wire logic                pll_off,
  input  wire logic                single_clock,
  // Read return
  output logic                     rd_valid,
  output logic [DATA_W-1:0]        rd_data0,
  output logic [DATA_W-1:0]        rd_data1,
  // Link
  sram_link_if.host                link
);
  localparam int AW = sram_link_pkg::addr_width(DATA_W);
  localparam int LN = DATA_W / sram_link_pkg::LANE_W;
  localparam int CW = 1 + AW + 2 * DATA_W + 2 * LN;

  logic              k_q, pbn_q, scm_q, rpe_n_q, wpe_n_q, wr_pend_q, second_q;
  logic [AW-1:0]     addr_q, wa_q;
  logic [DATA_W-1:0] d_q, wd1_q;
  logic [LN-1:0]     m_q, wm1_q;
  logic [CW-1:0]     head;
  logic              head_valid;

  // Pop only in the slot before a k rising edge, so the queue really fills
  wire               pop_slot = ~k_q;
  wire               take     = ce & pop_slot & head_valid;
  wire               h_write  = head[CW-1];
  wire [AW-1:0]      h_addr   = head[CW-2 -: AW];
  wire [DATA_W-1:0]  h_d0     = head[CW-2-AW -: DATA_W];
  wire [DATA_W-1:0]  h_d1     = head[CW-2-AW-DATA_W -: DATA_W];
  wire [LN-1:0]      h_m0     = head[2*LN-1 -: LN];
  wire [LN-1:0]      h_m1     = head[LN-1:0];

  cmd_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_write, cmd_addr, cmd_data0, cmd_data1, cmd_mask0_n, cmd_mask1_n}),
    .out_valid (head_valid),
    .out_ready (pop_slot),
    .out_data  (head)
  );

  // Both clock pairs move together from one flop
  assign link.k                      = k_q;
  assign link.k_n                    = ~k_q;
  assign link.c                      = k_q;
  assign link.c_n                    = ~k_q;
  assign link.addr                   = addr_q;
  assign link.read_port_enable_n     = rpe_n_q;
  assign link.write_port_enable_n    = wpe_n_q;
  assign link.d                      = d_q;
  assign link.byte_lane_write_mask_n = m_q;
  assign link.pll_bypass_n           = pbn_q;
  assign link.single_clock_mode      = scm_q;

  // Pin driving: k phase carries read address and first word, k_n the rest
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      k_q <= '0; pbn_q <= '1; scm_q <= '0; rpe_n_q <= '1; wpe_n_q <= '1;
      wr_pend_q <= '0; addr_q <= '0; wa_q <= '0; d_q <= '0; wd1_q <= '0;
      m_q <= '1; wm1_q <= '1;
    end else if (ce) begin
      k_q   <= ~k_q;
      pbn_q <= ~pll_off;
      scm_q <= single_clock;
      if (pop_slot) begin
        rpe_n_q   <= ~(take & ~h_write);
        wpe_n_q   <= ~(take & h_write);
        wr_pend_q <= take & h_write;
        addr_q    <= h_addr;
        d_q       <= h_d0;
        m_q       <= take & h_write ? h_m0 : '1;
        wa_q      <= h_addr;
        wd1_q     <= h_d1;
        wm1_q     <= h_m1;
      end else begin
        rpe_n_q <= '1;
        wpe_n_q <= '1;
        addr_q  <= wa_q;
        d_q     <= wd1_q;
        m_q     <= wr_pend_q ? wm1_q : '1;
      end
    end
  end

  // Pair returned words; bursts are always two words long
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_q <= '0; rd_valid <= '0; rd_data0 <= '0; rd_data1 <= '0;
    end else if (ce) begin
      rd_valid <= link.q_oe & second_q;
      second_q <= link.q_oe & ~second_q;
      if (link.q_oe & ~second_q) rd_data0 <= link.q;
      if (link.q_oe & second_q) rd_data1 <= link.q;
    end
  end
endmodule // sram_port_host
`default_nettype wire

/* File: hw/sram_port_device.sv */
// Burst memory end: split read and write ports, two-word bursts.
// Assumes link pins are synchronous to clock; k high marks a k rising edge.
`timescale 1ns/1ns
`default_nettype none
module sram_port_device #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF,
  parameter int MEM_AW = sram_link_pkg::MEM_AW_DEF
) (
  // Clocking
  input  wire logic   clock,
  input  wire logic   rst_b,
  input  wire logic   ce,
  // Link
  sram_link_if.device link
);
  localparam int AW    = sram_link_pkg::addr_width(DATA_W);
  localparam int LANES = DATA_W / sram_link_pkg::LANE_W;
  localparam int LW    = sram_link_pkg::LANE_W;
  localparam int DEPTH = 1 << MEM_AW;
  localparam int PL    = sram_link_pkg::PIPE_LEN;

  // Storage: one array per burst word
  logic [DATA_W-1:0] mem0_q [DEPTH];
  logic [DATA_W-1:0] mem1_q [DEPTH];

  // Write port state between the k and k_n edges
  logic              wr_pend_q;
  logic [DATA_W-1:0] wr_d0_q;
  logic [LANES-1:0]  wr_m0_n_q;

  // Read pipeline, one stage per phase
  logic [PL-1:0]     rd_v_q;
  logic [MEM_AW-1:0] rd_a_q [PL];

  // Output side
  logic [DATA_W-1:0] q_q;
  logic              q_oe_q;
  logic              hold_q;
  logic [DATA_W-1:0] hold_d_q;
  logic              echo_q;
  logic              echo_n_q;

  // Phase decode of the input clock pair
  wire pos_edge = link.k & ~link.k_n;
  wire neg_edge = link.k_n & ~link.k;

  // Port selects gate the read take and the write take; the address is used ungated
  wire rd_take = pos_edge & ~link.read_port_enable_n;
  wire wr_take = pos_edge & ~link.write_port_enable_n;
  wire commit  = neg_edge & wr_pend_q;

  // Low address bits index the flip-flop store; upper bits are dropped
  wire [MEM_AW-1:0] rd_idx_in = link.addr[MEM_AW-1:0];
  wire [MEM_AW-1:0] wr_idx    = link.addr[MEM_AW-1:0];

  // Latency choice from the bypass pin
  wire              bypass  = ~link.pll_bypass_n;
  wire              launch  = bypass ? rd_v_q[sram_link_pkg::LAT_BYPASS_PH - 1]
                                     : rd_v_q[sram_link_pkg::LAT_PLL_PH - 1];
  wire [MEM_AW-1:0] rd_idx  = bypass ? rd_a_q[sram_link_pkg::LAT_BYPASS_PH - 1]
                                     : rd_a_q[sram_link_pkg::LAT_PLL_PH - 1];

  // Merged words: old contents with unmasked lanes replaced
  logic [DATA_W-1:0] new0;
  logic [DATA_W-1:0] new1;
  logic [DATA_W-1:0] old0;
  logic [DATA_W-1:0] old1;

  assign old0 = mem0_q[wr_idx];
  assign old1 = mem1_q[wr_idx];

  // Per-lane masking; a high mask bit keeps the old byte
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign new0[g*LW +: LW] = wr_m0_n_q[g] ? old0[g*LW +: LW]
                                           : wr_d0_q[g*LW +: LW];
    assign new1[g*LW +: LW] = link.byte_lane_write_mask_n[g]
                              ? old1[g*LW +: LW]
                              : link.d[g*LW +: LW];
  end

  // Forward a write that lands in the same cycle as a read launch
  wire              hit    = commit & (wr_idx == rd_idx);
  wire [DATA_W-1:0] out0   = hit ? new0 : mem0_q[rd_idx];
  wire [DATA_W-1:0] out1   = hit ? new1 : mem1_q[rd_idx];

  // Echo source follows the input pair in single clock mode
  wire echo_src = link.single_clock_mode ? link.k : link.c;

  assign link.q             = q_q;
  assign link.q_oe          = q_oe_q;
  assign link.echo_strobe   = echo_q;
  assign link.echo_strobe_n = echo_n_q;

  // First write word and its mask are held until the k_n edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= '0;
      wr_d0_q   <= '0;
      wr_m0_n_q <= '1;
    end else if (ce) begin
      if (pos_edge) begin
        wr_pend_q <= wr_take;
        wr_d0_q   <= link.d;
        wr_m0_n_q <= link.byte_lane_write_mask_n;
      end else if (commit) begin
        wr_pend_q <= '0;
      end
    end
  end

  // Both words are written together on the k_n edge
  always_ff @(posedge clock) begin
    if (ce && commit) begin
      mem0_q[wr_idx] <= new0;
      mem1_q[wr_idx] <= new1;
    end
  end

  // Read requests march down the pipe one phase per clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_v_q <= '0;
    end else if (ce) begin
      rd_v_q <= {rd_v_q[PL-2:0], rd_take};
    end
  end

  // Address pipe needs no reset; validity travels beside it
  always_ff @(posedge clock) begin
    if (ce) begin
      rd_a_q[0] <= rd_idx_in;
      for (int i = 1; i < PL; i++) begin
        rd_a_q[i] <= rd_a_q[i-1];
      end
    end
  end

  // Launch word one, then word two, then float if nothing follows.
  // Word two is copied at launch so a later write cannot split the burst.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_q      <= '0;
      q_oe_q   <= '0;
      hold_q   <= '0;
      hold_d_q <= '0;
    end else if (ce) begin
      if (launch) begin
        q_q      <= out0;
        q_oe_q   <= '1;
        hold_q   <= '1;
        hold_d_q <= out1;
      end else if (hold_q) begin
        q_q    <= hold_d_q;
        hold_q <= '0;
      end else begin
        q_oe_q <= '0;
      end
    end
  end

  // Echo strobe runs free, even with no reads in flight; both pins from flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      echo_q   <= '0;
      echo_n_q <= '1;
    end else if (ce) begin
      echo_q   <= echo_src;
      echo_n_q <= ~echo_src;
    end
  end
endmodule // sram_port_device
`default_nettype wire

/* File: bench/sram_link_assertions.sv */
// Checker for the split-port burst memory link, watching interface signals.
// Assumes one clock, k toggling every clock while ce stays high.
`timescale 1ns/1ns
`default_nettype none
module sram_link_assertions #(
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF
) (
  // Clocking
  input wire logic                clock,
  input wire logic                rst_b,
  // Link pins
  input wire logic                k,
  input wire logic                k_n,
  input wire logic                c,
  input wire logic                c_n,
  input wire logic                read_port_enable_n,
  input wire logic                write_port_enable_n,
  input wire logic                q_oe,
  input wire logic                echo_strobe,
  input wire logic                echo_strobe_n,
  input wire logic                pll_bypass_n,
  input wire logic                single_clock_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Read taken on a k edge
  wire logic rd_take;
  assign rd_take = k & ~read_port_enable_n;

  // Burst windows, in phases after the taking edge
  sequence burst_pll;
    ##4 q_oe ##1 q_oe;
  endsequence
  sequence burst_bypass;
    ##3 q_oe ##1 q_oe;
  endsequence

  a_clock_pairs: assert property (k_n == ~k && c == k && c_n == ~c)
    else $error("clock pair mismatch");
  a_k_alternates: assert property (k |=> !k ##1 k)
    else $error("k does not alternate");
  a_select_on_k: assert property ((!read_port_enable_n || !write_port_enable_n) |-> k)
    else $error("port select outside k phase");
  a_write_second_word: assert property ((k && !write_port_enable_n) |=> (!k && write_port_enable_n))
    else $error("write second phase wrong");
  a_read_pll_burst: assert property ((rd_take && pll_bypass_n) |-> burst_pll)
    else $error("read burst late or short");
  a_read_bypass_burst: assert property ((rd_take && !pll_bypass_n) |-> burst_bypass)
    else $error("bypass read burst wrong");
  // Output enable only inside a burst window; catches late tristate
  a_no_stray_drive: assert property (q_oe |-> (pll_bypass_n ?
      ($past(rd_take, 4) || $past(rd_take, 5)) : ($past(rd_take, 3) || $past(rd_take, 4))))
    else $error("read outputs driven outside a burst");
  a_echo_follows: assert property (echo_strobe_n == ~echo_strobe &&
      echo_strobe == (single_clock_mode ? $past(k) : $past(c)))
    else $error("echo strobe not following its clock");
endmodule // sram_link_assertions
`default_nettype wire

/* File: bench/separate_port_ddr_sram_pins_bench.sv */
// Testbench joining controller end and memory end across the link.
// Assumes default widths; expectations come from lane arithmetic here.
`timescale 1ns/1ns
`default_nettype none
module separate_port_ddr_sram_pins_bench;
  localparam int DW = sram_link_pkg::DATA_W_DEF;
  localparam int AW = sram_link_pkg::addr_width(DW);
  localparam int LN = DW / sram_link_pkg::LANE_W;

  logic clock, rst_b, ce, cmd_valid, cmd_ready, cmd_write, pll_off, single_clock, rd_valid;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_data0, cmd_data1, rd_data0, rd_data1;
  logic [LN-1:0] cmd_mask0_n, cmd_mask1_n;
  logic [2*DW-1:0] rd_q[$];
  logic saw_full;
  int n_mismatch, cmp_count;

  sram_link_if #(.DATA_W(DW)) lnk ();

  sram_port_host #(.DATA_W(DW)) u_sram_port_host (.clock(clock), .rst_b(rst_b), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_data0(cmd_data0), .cmd_data1(cmd_data1), .cmd_mask0_n(cmd_mask0_n),
    .cmd_mask1_n(cmd_mask1_n), .pll_off(pll_off), .single_clock(single_clock),
    .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1), .link(lnk));
  sram_port_device #(.DATA_W(DW)) u_sram_port_device (.clock(clock), .rst_b(rst_b), .ce(ce),
    .link(lnk));
  sram_link_assertions #(.DATA_W(DW)) u_sram_link_assertions (.clock(clock), .rst_b(rst_b),
    .k(lnk.k), .k_n(lnk.k_n), .c(lnk.c), .c_n(lnk.c_n),
    .read_port_enable_n(lnk.read_port_enable_n), .write_port_enable_n(lnk.write_port_enable_n),
    .q_oe(lnk.q_oe), .echo_strobe(lnk.echo_strobe), .echo_strobe_n(lnk.echo_strobe_n),
    .pll_bypass_n(lnk.pll_bypass_n), .single_clock_mode(lnk.single_clock_mode));

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Collect read pairs; reads may return while commands are still queued
  always @(posedge clock) begin
    if (rd_valid === 1'b1) rd_q.push_back({rd_data0, rd_data1});
  end

  task automatic check(input logic [2*DW-1:0] seen, input logic [2*DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Lanes whose mask bit is low take new data, the rest keep old
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                          input logic [LN-1:0] m_n);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < LN; i++) if (!m_n[i]) r[i*9 +: 9] = nw[i*9 +: 9];
    return r;
  endfunction

  // Offer one command, hold it until the queue takes it
  task automatic send(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d0,
                      input logic [DW-1:0] d1, input logic [LN-1:0] m0, input logic [LN-1:0] m1);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_data0 <= d0;
    cmd_data1 <= d1;
    cmd_mask0_n <= m0;
    cmd_mask1_n <= m1;
    do begin
      @(posedge clock);
      if (cmd_ready === 1'b0) saw_full = 1'b1;
    end while (cmd_ready !== 1'b1);
  endtask

  // Wait, bounded, for the next read pair
  task automatic expect_rd(input logic [DW-1:0] e0, input logic [DW-1:0] e1);
    int n;
    n = 0;
    while (rd_q.size() == 0 && n < 64) begin
      @(posedge clock);
      n++;
    end
    if (rd_q.size() != 0) check(rd_q.pop_front(), {e0, e1});
    else check('0, 'x);
  endtask

  // Masked write over old data, read straight after it
  task automatic t_masks();
    send(1'b1, 22'h5, 18'h0a5a5, 18'h15a5a, 2'b00, 2'b00);
    send(1'b1, 22'h5, 18'h3c3c3, 18'h2d2d2, 2'b10, 2'b01);
    send(1'b0, 22'h5, '0, '0, '1, '1);
    cmd_valid <= 1'b0;
    expect_rd(merge(18'h0a5a5, 18'h3c3c3, 2'b10), merge(18'h15a5a, 18'h2d2d2, 2'b01));
  endtask

  // Normal, bypass and single clock modes; outputs float after each burst
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      pll_off <= (i == 1);
      single_clock <= (i == 2);
      repeat (4) @(posedge clock);
      send(1'b1, AW'(i + 8), DW'(18'h00100 + i), DW'(18'h3fe00 - i), '0, '0);
      send(1'b0, AW'(i + 8), '0, '0, '1, '1);
      cmd_valid <= 1'b0;
      expect_rd(DW'(18'h00100 + i), DW'(18'h3fe00 - i));
      @(posedge clock);
      check(36'(lnk.q_oe), 36'h0);
    end
    pll_off <= 1'b0;
    single_clock <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // Twenty back-to-back reads, enough that the queue refuses some, then drain them
  task automatic t_fill();
    send(1'b1, 22'h3, 18'h12345, 18'h2abcd, '0, '0);
    saw_full = 1'b0;
    for (int i = 0; i < 20; i++) send(1'b0, 22'h3, '0, '0, '1, '1);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 20; i++) expect_rd(18'h12345, 18'h2abcd);
    check(36'(saw_full), 36'h1);
  endtask

  // Second reset mid-run, then the link must work again
  task automatic t_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    check(36'(lnk.q_oe), 36'h0);
    rst_b <= 1'b1;
    @(posedge clock);
    send(1'b1, 22'h1, 18'h00abc, 18'h3f0f0, '0, '0);
    send(1'b0, 22'h1, '0, '0, '1, '1);
    cmd_valid <= 1'b0;
    expect_rd(18'h00abc, 18'h3f0f0);
  endtask

  // Watchdog, far beyond the few hundred cycles expected
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    saw_full = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_data0 = '0;
    cmd_data1 = '0;
    cmd_mask0_n = '1;
    cmd_mask1_n = '1;
    pll_off = 1'b0;
    single_clock = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_masks();
    t_modes();
    t_fill();
    t_reset();
    final_report();
  end
endmodule // separate_port_ddr_sram_pins_bench
`default_nettype wire
